/* File: design/ookmpc_pkg.sv */
package ookmpc_pkg;

  // Bus and field widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int OSR_W  = 11;
  localparam int NCO_W  = 20;
  localparam int GAIN_W = 11;
  localparam int BW_W   = 13;

  // Register offsets
  localparam logic [7:0] OFS_FILTER   = 8'h1c;
  localparam logic [7:0] OFS_OSR      = 8'h20;
  localparam logic [7:0] OFS_OFF_HIGH = 8'h21;
  localparam logic [7:0] OFS_OFF_MID  = 8'h22;
  localparam logic [7:0] OFS_OFF_LOW  = 8'h23;
  localparam logic [7:0] OFS_GAIN_HI  = 8'h24;
  localparam logic [7:0] OFS_GAIN_LO  = 8'h25;
  localparam logic [7:0] OFS_MOD_ONE  = 8'h70;
  localparam logic [7:0] OFS_MOD_TWO  = 8'h71;
  localparam logic [7:0] OFS_STATUS   = 8'h72;

  // Field positions
  localparam int SKIP_BIT    = 7;
  localparam int EXP_MSB     = 6;
  localparam int EXP_LSB     = 4;
  localparam int SEL_MSB     = 3;
  localparam int SEL_LSB     = 0;
  localparam int MANCH_BIT   = 0;
  localparam int MODTYP_MSB  = 1;
  localparam int MODTYP_LSB  = 0;
  localparam int OSR_LO_MSB  = 7;
  localparam int OSR_LO_LSB  = 5;
  localparam int NCO_HI_MSB  = 3;
  localparam int NCO_HI_LSB  = 0;
  localparam int GAIN_HI_MSB = 2;
  localparam int ST_VALID    = 0;
  localparam int ST_OOK      = 1;
  localparam int ST_LEGAL    = 2;
  localparam int ST_OSR_PEND = 3;
  localparam int ST_NCO_PEND = 4;
  localparam int ST_GN_PEND  = 5;

  // Registers per multi-byte field
  localparam int OSR_N  = 2;
  localparam int NCO_N  = 3;
  localparam int GAIN_N = 2;

  // Modulation type code for on-off keying
  localparam logic [1:0] MOD_OOK = 2'h1;

  // Reset values
  localparam logic [7:0] RST_FILTER  = 8'h01;
  localparam logic [7:0] RST_MOD_ONE = 8'h00;
  localparam logic [7:0] RST_MOD_TWO = 8'h00;
  localparam logic [7:0] RST_RECOVER = 8'h00;

  // Bandwidth in 100 Hz units, index {skip, select}, zero is illegal
  localparam logic [31:0][BW_W-1:0] BW_TAB = {
    13'h077b, 13'h183f, 13'h168a, 13'h1444,
    13'h124c, 13'h106a, 13'h0e22, 13'h0d1b,
    13'h0000, 13'h0000, 13'h0000, 13'h0b21,
    13'h0a85, 13'h09b8, 13'h08cb, 13'h0000,
    13'h0000, 13'h0000, 13'h0000, 13'h0000,
    13'h0000, 13'h0000, 13'h0000, 13'h0000,
    13'h0563, 13'h04ff, 13'h0461, 13'h03b9,
    13'h0384, 13'h0340, 13'h02f0, 13'h0000};

endpackage

/* File: design/ookmpc_bw_lut.sv */
`timescale 1ns/1ps
module ookmpc_bw_lut
  import ookmpc_pkg::*;
(
  // Filter fields
  input  wire logic                        skip_i,
  input  wire logic [3:0]                  sel_i,
  // Lookup result
  output logic      [ookmpc_pkg::BW_W-1:0] bw_o,
  output logic                             legal_o
);

  logic [4:0] index;

  always_comb
  begin
    index   = {skip_i, sel_i};
    bw_o    = BW_TAB[index];
    legal_o = |bw_o;
  end

endmodule

/* File: design/ookmpc_commit.sv */
`timescale 1ns/1ps
module ookmpc_commit
  import ookmpc_pkg::*;
#(
  parameter int N = 2
)
(
  // Clock, reset and enable
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Member writes, bit 0 is lowest address
  input  wire logic [N-1:0] wr_i,
  // Status
  output logic              commit_o,
  output logic [N-1:0]      pend_o,
  output logic              done_o
);

  typedef struct packed {
    logic [N-1:0] mask;
    logic         done;
  } ookmpc_commit_s;

  ookmpc_commit_s st;
  ookmpc_commit_s next_st;
  logic [N-1:0]   all_w;

  // Whole field written before it takes effect
  always_comb
  begin
    next_st  = st;
    all_w    = st.mask | wr_i;
    commit_o = ce_i && (|wr_i) && (&all_w);
    if (ce_i && (|wr_i))
    begin
      next_st.mask = commit_o ? '0 : all_w;
    end
    if (commit_o)
    begin
      next_st.done = 1'b1;
    end
    pend_o = st.mask;
    done_o = st.done;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule

/* File: design/ookmpc_top.sv */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
// Operation
// - OOK receive is entered when the modulation type at 71h holds OOK; the code also waits until every field except 70h is programmed.
// - In OOK only rate, Manchester, filter and oversampling are used; the code drives the offset and loop gain in OOK too.
// - The Manchester enable bit at 70h turns Manchester decoding on.
// - The channel filter bandwidth is chosen by the fields at 1Ch.
// - With skip clear, codes 1 to 7 give 75.2 up to 137.9 kHz.
// - With skip set, F gives 191.5, 1-4 and 8-14 give 225.1-620.7 kHz.
// - The 11-bit oversampling ratio spans the registers at 20h and 21h.
// - At 1Ch bit 7 is skip, bits 6:4 exponent, bits 3:0 filter code.
module ookmpc_top
  import ookmpc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  // Register port
  input  wire logic [ookmpc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [ookmpc_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [ookmpc_pkg::DATA_W-1:0] rd_data_o,
  // Modem settings
  output logic                               config_valid_o,
  output logic                               ook_active_o,
  output logic                               manch_en_o,
  output logic                               skip_o,
  output logic      [2:0]                    dec_exp_o,
  output logic      [3:0]                    filter_sel_o,
  output logic      [ookmpc_pkg::BW_W-1:0]   bw_o,
  output logic                               bw_legal_o,
  output logic      [ookmpc_pkg::OSR_W-1:0]  osr_o,
  output logic      [ookmpc_pkg::NCO_W-1:0]  nco_o,
  output logic      [ookmpc_pkg::GAIN_W-1:0] gain_o
);

  typedef struct packed {
    logic [DATA_W-1:0] filter;
    logic [DATA_W-1:0] mod_one;
    logic [DATA_W-1:0] mod_two;
    logic [DATA_W-1:0] osr_hi;
    logic [DATA_W-1:0] off_hi;
    logic [DATA_W-1:0] off_mid;
    logic [DATA_W-1:0] off_lo;
    logic [DATA_W-1:0] gain_hi;
    logic [DATA_W-1:0] gain_lo;
    logic [OSR_W-1:0]  osr;
    logic [NCO_W-1:0]  nco;
    logic [GAIN_W-1:0] gain;
    logic              filter_set;
    logic              mod_set;
    logic [DATA_W-1:0] rd_data;
    logic              cfg_valid;
    logic              ook;
    logic              manch;
    logic              skip;
    logic [2:0]        dec_exp;
    logic [3:0]        sel;
    logic [BW_W-1:0]   bw;
    logic              legal;
    logic [OSR_W-1:0]  osr_out;
    logic [NCO_W-1:0]  nco_out;
    logic [GAIN_W-1:0] gain_out;
  } ookmpc_top_s;

  ookmpc_top_s        st;
  ookmpc_top_s        next_st;
  logic               wr_en;
  logic [OSR_N-1:0]   osr_wr;
  logic [NCO_N-1:0]   nco_wr;
  logic [GAIN_N-1:0]  gain_wr;
  logic               osr_commit;
  logic               nco_commit;
  logic               gain_commit;
  logic [OSR_N-1:0]   osr_pend;
  logic [NCO_N-1:0]   nco_pend;
  logic [GAIN_N-1:0]  gain_pend;
  logic               osr_done;
  logic               nco_done;
  logic               gain_done;
  logic [DATA_W-1:0]  filter_nx;
  logic [BW_W-1:0]    lut_bw;
  logic               lut_legal;

  // Member strobes of each multi-byte field
  always_comb
  begin
    wr_en   = ce_i && wr_i;
    filter_nx = (wr_en && addr_i == OFS_FILTER) ? wr_data_i : st.filter;
    osr_wr  = {wr_en && addr_i == OFS_OFF_HIGH,
               wr_en && addr_i == OFS_OSR};
    nco_wr  = {wr_en && addr_i == OFS_OFF_LOW,
               wr_en && addr_i == OFS_OFF_MID,
               wr_en && addr_i == OFS_OFF_HIGH};
    gain_wr = {wr_en && addr_i == OFS_GAIN_LO,
               wr_en && addr_i == OFS_GAIN_HI};
  end

  ookmpc_commit #(.N(OSR_N)) u_osr_commit (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .wr_i     (osr_wr),
    .commit_o (osr_commit),
    .pend_o   (osr_pend),
    .done_o   (osr_done)
  );

  ookmpc_commit #(.N(NCO_N)) u_nco_commit (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .wr_i     (nco_wr),
    .commit_o (nco_commit),
    .pend_o   (nco_pend),
    .done_o   (nco_done)
  );

  ookmpc_commit #(.N(GAIN_N)) u_gain_commit (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .wr_i     (gain_wr),
    .commit_o (gain_commit),
    .pend_o   (gain_pend),
    .done_o   (gain_done)
  );

  ookmpc_bw_lut u_bw_lut (
    .skip_i  (filter_nx[SKIP_BIT]),
    .sel_i   (filter_nx[SEL_MSB:SEL_LSB]),
    .bw_o    (lut_bw),
    .legal_o (lut_legal)
  );

  always_comb
  begin
    next_st = st;
    if (ce_i)
    begin
      // Register writes
      if (wr_i)
      begin
        if (addr_i == OFS_FILTER)
        begin
          next_st.filter     = wr_data_i;
          next_st.filter_set = 1'b1;
        end
        else if (addr_i == OFS_OSR)
          next_st.osr_hi = wr_data_i;
        else if (addr_i == OFS_OFF_HIGH)
          next_st.off_hi = wr_data_i;
        else if (addr_i == OFS_OFF_MID)
          next_st.off_mid = wr_data_i;
        else if (addr_i == OFS_OFF_LOW)
          next_st.off_lo = wr_data_i;
        else if (addr_i == OFS_GAIN_HI)
          next_st.gain_hi = wr_data_i;
        else if (addr_i == OFS_GAIN_LO)
          next_st.gain_lo = wr_data_i;
        else if (addr_i == OFS_MOD_ONE)
          next_st.mod_one = wr_data_i;
        else if (addr_i == OFS_MOD_TWO)
        begin
          next_st.mod_two = wr_data_i;
          next_st.mod_set = 1'b1;
        end
      end
      // Register reads, data stand one cycle
      next_st.rd_data = '0;
      if (rd_i)
      begin
        if (addr_i == OFS_FILTER)
          next_st.rd_data = st.filter;
        else if (addr_i == OFS_OSR)
          next_st.rd_data = st.osr_hi;
        else if (addr_i == OFS_OFF_HIGH)
          next_st.rd_data = st.off_hi;
        else if (addr_i == OFS_OFF_MID)
          next_st.rd_data = st.off_mid;
        else if (addr_i == OFS_OFF_LOW)
          next_st.rd_data = st.off_lo;
        else if (addr_i == OFS_GAIN_HI)
          next_st.rd_data = st.gain_hi;
        else if (addr_i == OFS_GAIN_LO)
          next_st.rd_data = st.gain_lo;
        else if (addr_i == OFS_MOD_ONE)
          next_st.rd_data = st.mod_one;
        else if (addr_i == OFS_MOD_TWO)
          next_st.rd_data = st.mod_two;
        else if (addr_i == OFS_STATUS)
        begin
          next_st.rd_data[ST_VALID]    = st.cfg_valid;
          next_st.rd_data[ST_OOK]      = st.ook;
          next_st.rd_data[ST_LEGAL]    = st.legal;
          next_st.rd_data[ST_OSR_PEND] = |osr_pend;
          next_st.rd_data[ST_NCO_PEND] = |nco_pend;
          next_st.rd_data[ST_GN_PEND]  = |gain_pend;
        end
      end
      if (osr_commit)
        next_st.osr = {next_st.osr_hi,
                       next_st.off_hi[OSR_LO_MSB:OSR_LO_LSB]};
      // Offset applies after all three bytes
      if (nco_commit)
        next_st.nco = {next_st.off_hi[NCO_HI_MSB:NCO_HI_LSB],
                       next_st.off_mid, next_st.off_lo};
      // Loop gain applies after both bytes
      if (gain_commit)
        next_st.gain = {next_st.gain_hi[GAIN_HI_MSB:0],
                        next_st.gain_lo};
      // Nothing used until every field except 70h programmed
      next_st.cfg_valid = next_st.filter_set && next_st.mod_set &&
                          (osr_done || osr_commit) &&
                          (nco_done || nco_commit) &&
                          (gain_done || gain_commit);
      // OOK mode from the modulation type
      next_st.ook = next_st.cfg_valid &&
        next_st.mod_two[MODTYP_MSB:MODTYP_LSB] == MOD_OOK;
      // Settings reach the modem only in OOK mode, offset and loop gain included
      next_st.manch    = '0;
      next_st.skip     = '0;
      next_st.dec_exp  = '0;
      next_st.sel      = '0;
      next_st.bw       = '0;
      next_st.legal    = '0;
      next_st.osr_out  = '0;
      next_st.nco_out  = '0;
      next_st.gain_out = '0;
      if (next_st.ook)
      begin
        next_st.manch    = next_st.mod_one[MANCH_BIT];
        next_st.skip     = next_st.filter[SKIP_BIT];
        next_st.dec_exp  = next_st.filter[EXP_MSB:EXP_LSB];
        next_st.sel      = next_st.filter[SEL_MSB:SEL_LSB];
        next_st.bw       = lut_bw;
        next_st.legal    = lut_legal;
        next_st.osr_out  = next_st.osr;
        next_st.nco_out  = next_st.nco;
        next_st.gain_out = next_st.gain;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st         <= '0;
      st.filter  <= RST_FILTER;
      st.mod_one <= RST_MOD_ONE;
      st.mod_two <= RST_MOD_TWO;
      st.osr_hi  <= RST_RECOVER;
      st.off_hi  <= RST_RECOVER;
      st.off_mid <= RST_RECOVER;
      st.off_lo  <= RST_RECOVER;
      st.gain_hi <= RST_RECOVER;
      st.gain_lo <= RST_RECOVER;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_data_o      = st.rd_data;
  assign config_valid_o = st.cfg_valid;
  assign ook_active_o   = st.ook;
  assign manch_en_o     = st.manch;
  assign skip_o         = st.skip;
  assign dec_exp_o      = st.dec_exp;
  assign filter_sel_o   = st.sel;
  assign bw_o           = st.bw;
  assign bw_legal_o     = st.legal;
  assign osr_o          = st.osr_out;
  assign nco_o          = st.nco_out;
  assign gain_o         = st.gain_out;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_osr_hi_write;
    ce_i && wr_i && addr_i == OFS_OSR && osr_pend == '0;
  endsequence

  sequence s_osr_lo_write;
    ce_i && wr_i && addr_i == OFS_OFF_HIGH;
  endsequence

  sequence s_ook_select;
    ce_i && wr_i && addr_i == OFS_MOD_TWO && config_valid_o &&
    wr_data_i[MODTYP_MSB:MODTYP_LSB] == MOD_OOK;
  endsequence

  a_ook_mode_entry: assert property (
    s_ook_select |=> ook_active_o)
    else $error("OOK mode not entered after type write");

  a_idle_outputs_zero: assert property (
    !ook_active_o |-> osr_o == '0 && nco_o == '0 && gain_o == '0 &&
                      !manch_en_o && bw_o == '0)
    else $error("Settings driven outside OOK mode");

  a_manch_bit_follow: assert property (
    (ook_active_o && ce_i && wr_i && addr_i == OFS_MOD_ONE) |=>
    manch_en_o == $past(wr_data_i[MANCH_BIT]))
    else $error("Manchester enable not taken from 70h");

  a_filter_field_map: assert property (
    (ook_active_o && ce_i && wr_i && addr_i == OFS_FILTER) |=>
    {skip_o, dec_exp_o, filter_sel_o} == $past(wr_data_i))
    else $error("Filter fields not split as expected");

  a_low_band_range: assert property (
    (ook_active_o && !skip_o && filter_sel_o inside {[1:7]}) |->
    bw_legal_o && bw_o >= BW_TAB[1] && bw_o <= BW_TAB[7])
    else $error("Low band bandwidth out of range");

  a_high_band_range: assert property (
    (ook_active_o && skip_o && filter_sel_o == 4'hf) |->
    bw_o == BW_TAB[31] && bw_o < BW_TAB[17])
    else $error("Skip band code F wrong bandwidth");

  a_osr_pair_commit: assert property (
    s_osr_hi_write ##1 s_osr_lo_write |=>
    st.osr == {$past(wr_data_i, 2),
               $past(wr_data_i[OSR_LO_MSB:OSR_LO_LSB])})
    else $error("Oversampling ratio not assembled");

  a_osr_half_held: assert property (
    s_osr_hi_write |=> $stable(st.osr))
    else $error("Ratio changed before both bytes written");

  a_reset_clears_use: assert property (
    $past(rst_i) |-> !config_valid_o && !ook_active_o && osr_o == '0)
    else $error("Block in use right after reset");

  a_no_early_use: assert property (
    !config_valid_o |-> !ook_active_o && !bw_legal_o)
    else $error("Settings used before programming");

endmodule

/* File: verification/ookmpc_top_test.sv */
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("[ERR] %0t got %h expected %h", $time, got, exp); \
    end \
  end

module ookmpc_top_test;
  import ookmpc_pkg::*;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] rb;
  } ookmpc_row_s;

  logic              clk;
  logic              rst;
  logic              ce;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              cfg_valid;
  logic              ook;
  logic              manch;
  logic              skip;
  logic [2:0]        dexp;
  logic [3:0]        fsel;
  logic [BW_W-1:0]   bw;
  logic              legal;
  logic [OSR_W-1:0]  osr;
  logic [NCO_W-1:0]  nco;
  logic [GAIN_W-1:0] gain;
  int                errors;
  int                samples_checked;

  // Expected bandwidth in 100 Hz units, index is the select code
  logic [BW_W-1:0] bw_lo [16] = '{13'h0, 13'h2f0, 13'h340, 13'h384,
    13'h3b9, 13'h461, 13'h4ff, 13'h563, 13'h0, 13'h0, 13'h0, 13'h0,
    13'h0, 13'h0, 13'h0, 13'h0};
  logic [BW_W-1:0] bw_hi [16] = '{13'h0, 13'h8cb, 13'h9b8, 13'ha85,
    13'hb21, 13'h0, 13'h0, 13'h0, 13'hd1b, 13'he22, 13'h106a, 13'h124c,
    13'h1444, 13'h168a, 13'h183f, 13'h77b};

  // Program a 1.2 kbps setting, skip set, exponent 4, code 8
  // Exponent 4 for 1.2 kbps, Manchester off
  // Ratio 625, offset 0346e, gain 06b
  ookmpc_row_s rows [11] = '{
    '{8'h1c, 8'hc8, 8'hc8}, '{8'h20, 8'h4e, 8'h4e},
    '{8'h21, 8'h20, 8'h20}, '{8'h22, 8'h34, 8'h34},
    '{8'h23, 8'h6e, 8'h6e}, '{8'h24, 8'h00, 8'h00},
    '{8'h25, 8'h6b, 8'h6b}, '{8'h70, 8'h00, 8'h00},
    '{8'h71, 8'h01, 8'h01}, '{8'h30, 8'h5a, 8'h00},
    '{8'h72, 8'hff, 8'h07}};

  ookmpc_top dut (
    .clk_i          (clk),
    .rst_i          (rst),
    .ce_i           (ce),
    .addr_i         (addr),
    .wr_data_i      (wdata),
    .wr_i           (wr),
    .rd_i           (rd),
    .rd_data_o      (rdata),
    .config_valid_o (cfg_valid),
    .ook_active_o   (ook),
    .manch_en_o     (manch),
    .skip_o         (skip),
    .dec_exp_o      (dexp),
    .filter_sel_o   (fsel),
    .bw_o           (bw),
    .bw_legal_o     (legal),
    .osr_o          (osr),
    .nco_o          (nco),
    .gain_o         (gain)
  );

  always #5 clk = ~clk;

  task automatic summarize;
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data stands one cycle, then returns to zero
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    `CHK(rdata, e) // read path
    @(posedge clk);
    #1;
    `CHK(rdata, 8'h00) // read strobe
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end

  initial
  begin
    clk   = 1'b0;
    rst   = 1'b1;
    ce    = 1'b1;
    addr  = '0;
    wdata = '0;
    wr    = 1'b0;
    rd    = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle();
    `CHK(cfg_valid, 1'b0) // defaults
    `CHK(osr, 11'h000) // defaults
    rd_chk(8'h1c, 8'h01); // filter default
    rd_chk(8'h71, 8'h00); // mode default
    for (int i = 0; i < 11; i++)
    begin
      wr_reg(rows[i].addr, rows[i].data);
      rd_chk(rows[i].addr, rows[i].rb); // readback
    end
    settle();
    `CHK(cfg_valid, 1'b1) // programmed
    `CHK(ook, 1'b1) // mode code
    `CHK(manch, 1'b0) // decoding off
    `CHK({skip, dexp, fsel}, 8'hc8) // field split
    `CHK(bw, 13'hd1b) // bandwidth
    `CHK(legal, 1'b1) // legal code
    `CHK(osr, 11'h271) // ratio
    `CHK(nco, 20'h0346e) // offset
    `CHK(gain, 11'h06b) // gain
    // Partial field keeps the old value
    wr_reg(8'h20, 8'h25);
    settle();
    `CHK(osr, 11'h271) // staged byte
    wr_reg(8'h21, 8'h40);
    settle();
    `CHK(osr, 11'h12a) // completed ratio
    `CHK(nco, 20'h0346e) // offset pending
    rd_chk(8'h72, 8'h17); // pending flag
    wr_reg(8'h22, 8'h69);
    wr_reg(8'h23, 8'hd0);
    settle();
    `CHK(nco, 20'h069d0) // completed offset
    wr_reg(8'h24, 8'h05);
    wr_reg(8'h24, 8'h01);
    settle();
    `CHK(gain, 11'h06b) // staged gain
    wr_reg(8'h25, 8'h3d);
    settle();
    `CHK(gain, 11'h13d) // overwritten byte
    wr_reg(8'h70, 8'h01);
    settle();
    `CHK(manch, 1'b1) // decoding on
    wr_reg(8'h71, 8'h02);
    settle();
    `CHK(ook, 1'b0) // other mode
    `CHK({manch, skip, osr, nco, gain}, '0) // settings unused
    wr_reg(8'h71, 8'h01);
    // Every select code with skip clear and set
    for (int s = 0; s < 2; s++)
    begin
      for (int c = 0; c < 16; c++)
      begin
        wr_reg({s[0], 3'h0, c[3:0]}, 8'h00);
        wr_reg(8'h1c, {s[0], 3'h0, c[3:0]});
        settle();
        `CHK(bw, s ? bw_hi[c] : bw_lo[c]) // table
        `CHK(legal, (s ? bw_hi[c] : bw_lo[c]) != 0) // legality
        `CHK({skip, fsel}, {s[0], c[3:0]}) // field split
      end
    end
    // Ratio bytes back to back
    @(posedge clk);
    addr  <= 8'h20;
    wdata <= 8'h4e;
    wr    <= 1'b1;
    @(posedge clk);
    addr  <= 8'h21;
    wdata <= 8'h20;
    @(posedge clk);
    wr    <= 1'b0;
    settle();
    `CHK(osr, 11'h271) // back to back
    // Disabled clock enable drops the write
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(8'h70, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    rd_chk(8'h70, 8'h01); // frozen write
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle();
    `CHK({cfg_valid, ook, osr}, '0) // second reset
    rd_chk(8'h1c, 8'h01); // filter default
    rd_chk(8'h70, 8'h00); // control default
    summarize();
  end
endmodule
